// >>> src/dpa_pkg.sv
package dpa_pkg;

  // --------------------------------------------------------------------
  // widths and counts
  // --------------------------------------------------------------------
  localparam int          PTR_W       = 32;
  localparam int          BIT_DIV_DEF = 16;
  localparam logic [3:0]  KEY_BYTES   = 4'h8;
  localparam logic [63:0] KEY_VALUE   = 64'h1289AB45CDD888FF;

  // --------------------------------------------------------------------
  // instruction classes, bits 7:5 of an instruction byte
  // --------------------------------------------------------------------
  localparam logic [2:0] OP_LD_DIR   = 3'h0;
  localparam logic [2:0] OP_LD_IND   = 3'h1;
  localparam logic [2:0] OP_ST_DIR   = 3'h2;
  localparam logic [2:0] OP_ST_IND   = 3'h3;
  localparam logic [2:0] OP_CS_LOAD  = 3'h4;
  localparam logic [2:0] OP_REPEAT   = 3'h5;
  localparam logic [2:0] OP_CS_STORE = 3'h6;
  localparam logic [2:0] OP_KEY      = 3'h7;

  // pointer modes for indirect access, bits 3:2
  localparam logic [1:0] PM_PTR      = 2'h0;
  localparam logic [1:0] PM_PTR_INC  = 2'h1;
  localparam logic [1:0] PM_REG      = 2'h2;
  localparam logic [1:0] PM_REG_INC  = 2'h3;

  // --------------------------------------------------------------------
  // control_status_space map
  // --------------------------------------------------------------------
  localparam logic [1:0] CS_STATUS_OFS = 2'h0;
  localparam logic [1:0] CS_RESET_OFS  = 2'h1;
  localparam logic [1:0] CS_CTRL_OFS   = 2'h2;
  localparam logic [1:0] CS_RSVD_OFS   = 2'h3;
  localparam int         NVM_EN_BIT    = 1;
  localparam int         RST_STATE_BIT = 0;
  localparam logic [7:0] RESET_SIG     = 8'h59;
  localparam logic [7:0] RESET_REG_RST = 8'h00;
  localparam logic [2:0] GUARD_RST     = 3'h0;

  // --------------------------------------------------------------------
  // carriers and states
  // --------------------------------------------------------------------
  typedef struct packed {
    logic [2:0] op;
    logic       rsvd;
    logic [1:0] amode;
    logic [1:0] dsize;
  } dpa_instr_t;

  typedef struct packed {
    logic [7:0] data;
    logic       valid;
  } dpa_byte_t;

  typedef struct packed {
    logic [PTR_W-1:0] addr;
    logic [7:0]       wdata;
    logic             rd;
    logic             wr;
  } dpa_bus_req_t;

  typedef enum logic [2:0] {
    ST_IDLE   = 3'h0,
    ST_OPND   = 3'h1,
    ST_RXDATA = 3'h3,
    ST_BUSWR  = 3'h2,
    ST_BUSRD  = 3'h6,
    ST_GUARD  = 3'h7,
    ST_TX     = 3'h5,
    ST_ERROR  = 3'h4
  } dpa_state_t;

  function automatic logic [7:0] dpa_guard_bits(input logic [2:0] sel);
    case (sel)
      3'h0:    return 8'h80;
      3'h1:    return 8'h40;
      3'h2:    return 8'h20;
      3'h3:    return 8'h10;
      3'h4:    return 8'h08;
      3'h5:    return 8'h04;
      default: return 8'h02;
    endcase
  endfunction

endpackage

// >>> src/dpa_csr_regs.sv
module dpa_csr_regs (
  // clock and reset
  input  wire logic       ref_clk_in,
  input  wire logic       sys_rst_in,
  // access
  input  wire logic [1:0] addr_in,
  input  wire logic       wr_in,
  input  wire logic [7:0] wdata_in,
  input  wire logic       key_ok_in,
  output logic      [7:0] rdata_out,
  // state
  output logic            nvm_en_out,
  output logic            device_reset_out,
  output logic      [2:0] guard_sel_out
);

  logic       nvm_en_reg;
  logic       nvm_en_next;
  logic       rst_reg;
  logic       rst_next;
  logic [2:0] guard_reg;
  logic [2:0] guard_next;
  wire        wr_status = wr_in && (addr_in == dpa_pkg::CS_STATUS_OFS);
  wire        wr_reset  = wr_in && (addr_in == dpa_pkg::CS_RESET_OFS);
  wire        wr_ctrl   = wr_in && (addr_in == dpa_pkg::CS_CTRL_OFS);

  // --------------------------------------------------------------------
  // next values
  // --------------------------------------------------------------------
  // set wins over the clearing write
  assign nvm_en_next = key_ok_in ? 1'b1 :
                       (wr_status ? 1'b0 : nvm_en_reg);
  assign rst_next    = wr_reset ? (wdata_in == dpa_pkg::RESET_SIG)
                                : rst_reg;
  assign guard_next  = wr_ctrl ? wdata_in[2:0] : guard_reg;

  // --------------------------------------------------------------------
  // read mux
  // --------------------------------------------------------------------
  always_comb begin
    rdata_out = 8'h00;
    case (addr_in)
      dpa_pkg::CS_STATUS_OFS: rdata_out[dpa_pkg::NVM_EN_BIT] = nvm_en_reg;
      dpa_pkg::CS_RESET_OFS:
        rdata_out[dpa_pkg::RST_STATE_BIT] = rst_reg;
      dpa_pkg::CS_CTRL_OFS:   rdata_out[2:0] = guard_reg;
      default:                rdata_out = 8'h00;
    endcase
  end

  always_ff @(posedge ref_clk_in or posedge sys_rst_in) begin
    if (sys_rst_in) begin
      nvm_en_reg <= 1'b0;
      rst_reg    <= 1'b0;
      guard_reg  <= dpa_pkg::GUARD_RST;
    end else begin
      nvm_en_reg <= nvm_en_next;
      rst_reg    <= rst_next;
      guard_reg  <= guard_next;
    end
  end

  assign nvm_en_out       = nvm_en_reg;
  assign device_reset_out = rst_reg;
  assign guard_sel_out    = guard_reg;

endmodule

// >>> src/dpa_ctrl_core.sv
// Notes on behaviour
// - direct access loads pointer from address operands
// - indirect access uses pointer, optional post-increment
// - indirect option reads or writes pointer itself
// - pointer bytes little-endian, one byte only LSB
// - control space never uses the pointer
// - repeat operand bytes copied into repeat counter
// - repeat counter decrements per run, stops at zero
// - repeat counter also counts key bytes
// - operand counter tracks bytes, control space excepted
// - control space single byte, own instructions only
// - key sets enable bit, a status register write clears it
// - signature write holds device in reset
// - reset register reads state in bit 0
// - guard idle bits on receive to transmit only
// - guard field encoding, default 128 bits
// - repeated instruction runs counter plus one times
// - last instruction kept for repeated decoding
// - link exception or break aborts, break in error returns to idle
module dpa_ctrl_core #(
  parameter int BIT_DIV = dpa_pkg::BIT_DIV_DEF
) (
  // clock and reset
  input  wire logic                  ref_clk_in,
  input  wire logic                  sys_rst_in,
  // link bytes to and from the physical layer
  input  wire dpa_pkg::dpa_byte_t    rx_in,
  input  wire logic                  link_exc_in,
  input  wire logic                  link_break_in,
  input  wire logic                  tx_ready_in,
  output logic                 [7:0] tx_byte_out,
  output logic                       tx_valid_out,
  output logic                       link_dir_tx_out,
  // internal_debug_bus
  output dpa_pkg::dpa_bus_req_t      bus_req_out,
  input  wire logic            [7:0] bus_rdata_in,
  input  wire logic                  bus_ack_in,
  // device control
  output logic                       nvm_en_out,
  output logic                       device_reset_out
);

  localparam int PW = dpa_pkg::PTR_W;

  // --------------------------------------------------------------------
  // helpers
  // --------------------------------------------------------------------
  function automatic logic [PW-1:0] put_byte(input logic [PW-1:0] v,
                                             input logic [1:0]    i,
                                             input logic [7:0]    b);
    logic [PW-1:0] r;
    r = v;
    r[{i, 3'h0} +: 8] = b;
    return r;
  endfunction

  function automatic logic [7:0] get_byte(input logic [PW-1:0] v,
                                          input logic [1:0]    i);
    return v[{i, 3'h0} +: 8];
  endfunction

  // --------------------------------------------------------------------
  // state
  // --------------------------------------------------------------------
  dpa_pkg::dpa_state_t state_reg;
  dpa_pkg::dpa_state_t state_next;
  dpa_pkg::dpa_instr_t instr_reg;
  dpa_pkg::dpa_instr_t instr_next;
  logic [PW-1:0]       ptr_reg;
  logic [PW-1:0]       ptr_next;
  logic [PW-1:0]       acc_reg;
  logic [PW-1:0]       acc_next;
  logic [PW-1:0]       rep_cnt_reg;
  logic [PW-1:0]       rep_cnt_next;
  logic [1:0]          cnt_reg;
  logic [1:0]          cnt_next;
  logic                addr_ph_reg;
  logic                addr_ph_next;
  logic                rep_arm_reg;
  logic                rep_arm_next;
  logic                rep_act_reg;
  logic                rep_act_next;
  logic                again_reg;
  logic                again_next;
  logic                dir_tx_reg;
  logic                dir_tx_next;
  logic [7:0]          tx_data_reg;
  logic [7:0]          tx_data_next;
  logic [7:0]          wdata_reg;
  logic [7:0]          wdata_next;
  logic [63:0]         key_sh_reg;
  logic [63:0]         key_sh_next;
  logic [7:0]          guard_cnt_reg;
  logic [7:0]          guard_cnt_next;
  logic [15:0]         div_cnt_reg;
  logic                bit_tick_reg;

  // combinational helpers
  logic                done;
  logic                key_ok;
  logic                csr_wr;
  logic [PW-1:0]       pb;
  logic [63:0]         key_in;
  dpa_pkg::dpa_state_t tx_enter;

  // --------------------------------------------------------------------
  // decode
  // --------------------------------------------------------------------
  wire dpa_pkg::dpa_instr_t cur =
    again_reg ? instr_reg : dpa_pkg::dpa_instr_t'(rx_in.data);
  wire        idle_st   = (state_reg == dpa_pkg::ST_IDLE);
  wire        disp_go   = idle_st && (again_reg || rx_in.valid);
  wire [1:0]  target    = addr_ph_reg ? instr_reg.amode : instr_reg.dsize;
  wire        last      = (cnt_reg == target);
  wire        ptr_self  = instr_reg.amode[1];
  wire        ptr_inc   = (instr_reg.amode == dpa_pkg::PM_PTR_INC);
  wire        rx_now    = rx_in.valid;
  wire [1:0]  csr_addr  = idle_st ? cur.dsize : instr_reg.dsize;
  wire [1:0]  cnt_inc   = cnt_reg + 2'h1;
  wire [7:0]  csr_rdata;
  wire [2:0]  guard_sel;
  wire        rep_able  = (cur.op != dpa_pkg::OP_REPEAT) &&
                          (cur.op != dpa_pkg::OP_KEY);
  wire        div_wrap  = (div_cnt_reg == 16'(BIT_DIV - 1));

  // --------------------------------------------------------------------
  // control_status_space
  // --------------------------------------------------------------------
  dpa_csr_regs u_csr (
    .ref_clk_in       (ref_clk_in),
    .sys_rst_in       (sys_rst_in),
    .addr_in          (csr_addr),
    .wr_in            (csr_wr),
    .wdata_in         (rx_in.data),
    .key_ok_in        (key_ok),
    .rdata_out        (csr_rdata),
    .nvm_en_out       (nvm_en_out),
    .device_reset_out (device_reset_out),
    .guard_sel_out    (guard_sel)
  );

  // --------------------------------------------------------------------
  // next-state logic
  // --------------------------------------------------------------------
  always_comb begin
    state_next     = state_reg;
    instr_next     = instr_reg;
    ptr_next       = ptr_reg;
    acc_next       = acc_reg;
    rep_cnt_next   = rep_cnt_reg;
    cnt_next       = cnt_reg;
    addr_ph_next   = addr_ph_reg;
    rep_arm_next   = rep_arm_reg;
    rep_act_next   = rep_act_reg;
    again_next     = again_reg;
    dir_tx_next    = dir_tx_reg;
    tx_data_next   = tx_data_reg;
    wdata_next     = wdata_reg;
    key_sh_next    = key_sh_reg;
    guard_cnt_next = guard_cnt_reg;
    done           = 1'b0;
    key_ok         = 1'b0;
    csr_wr         = 1'b0;
    pb             = put_byte(ptr_reg, cnt_reg, rx_in.data);
    key_in         = {rx_in.data, key_sh_reg[63:8]};
    // guard only when the link last ran in the receive direction
    tx_enter       = (dir_tx_reg && !rx_now) ? dpa_pkg::ST_TX
                                             : dpa_pkg::ST_GUARD;
    if (state_reg != dpa_pkg::ST_GUARD) begin
      guard_cnt_next = dpa_pkg::dpa_guard_bits(guard_sel);
    end
    if (rx_now && state_reg != dpa_pkg::ST_ERROR) begin
      dir_tx_next = 1'b0;
    end
    case (state_reg)
      dpa_pkg::ST_IDLE: begin
        if (disp_go) begin
          again_next   = 1'b0;
          cnt_next     = 2'h0;
          addr_ph_next = 1'b0;
          acc_next     = ptr_reg;
          if (!again_reg) begin
            instr_next   = cur;
            rep_arm_next = 1'b0;
            rep_act_next = rep_arm_reg && rep_able;
          end
          case (cur.op)
            dpa_pkg::OP_LD_DIR, dpa_pkg::OP_ST_DIR: begin
              addr_ph_next = 1'b1;
              state_next   = dpa_pkg::ST_OPND;
            end
            dpa_pkg::OP_REPEAT: state_next = dpa_pkg::ST_OPND;
            dpa_pkg::OP_KEY: begin
              rep_cnt_next = PW'(dpa_pkg::KEY_BYTES - 4'h1);
              state_next   = dpa_pkg::ST_OPND;
            end
            dpa_pkg::OP_LD_IND: begin
              if (cur.amode[1]) begin
                tx_data_next = ptr_reg[7:0];
                state_next   = tx_enter;
              end else begin
                state_next = dpa_pkg::ST_BUSRD;
              end
            end
            dpa_pkg::OP_CS_LOAD: begin
              tx_data_next = csr_rdata;
              state_next   = tx_enter;
            end
            default: state_next = dpa_pkg::ST_RXDATA;
          endcase
        end
      end
      dpa_pkg::ST_OPND: begin
        if (rx_now) begin
          cnt_next = cnt_inc;
          case (instr_reg.op)
            dpa_pkg::OP_REPEAT: begin
              rep_cnt_next = (cnt_reg == 2'h0) ? PW'(rx_in.data)
                           : put_byte(rep_cnt_reg, cnt_reg,
                                      rx_in.data);
              if (last) begin
                rep_arm_next = 1'b1;
                done         = 1'b1;
              end
            end
            dpa_pkg::OP_KEY: begin
              key_sh_next  = key_in;
              rep_cnt_next = rep_cnt_reg - PW'(1);
              if (rep_cnt_reg == '0) begin
                key_ok = (key_in == dpa_pkg::KEY_VALUE);
                done   = 1'b1;
              end
            end
            default: begin
              ptr_next = pb;
              if (last) begin
                addr_ph_next = 1'b0;
                cnt_next     = 2'h0;
                acc_next     = pb;
                state_next   = (instr_reg.op == dpa_pkg::OP_LD_DIR)
                             ? dpa_pkg::ST_BUSRD : dpa_pkg::ST_RXDATA;
              end
            end
          endcase
        end
      end
      dpa_pkg::ST_RXDATA: begin
        if (rx_now) begin
          if (instr_reg.op == dpa_pkg::OP_CS_STORE) begin
            csr_wr = 1'b1;
            done   = 1'b1;
          end else if (instr_reg.op == dpa_pkg::OP_ST_IND && ptr_self) begin
            ptr_next = pb;
            cnt_next = cnt_inc;
            done     = last;
          end else begin
            wdata_next = rx_in.data;
            state_next = dpa_pkg::ST_BUSWR;
          end
        end
      end
      dpa_pkg::ST_BUSWR: begin
        if (bus_ack_in) begin
          acc_next = acc_reg + PW'(1);
          if (instr_reg.op == dpa_pkg::OP_ST_IND && ptr_inc) begin
            ptr_next = ptr_reg + PW'(1);
          end
          cnt_next   = cnt_inc;
          done       = last;
          state_next = dpa_pkg::ST_RXDATA;
        end
      end
      dpa_pkg::ST_BUSRD: begin
        if (bus_ack_in) begin
          tx_data_next = bus_rdata_in;
          acc_next     = acc_reg + PW'(1);
          if (instr_reg.op == dpa_pkg::OP_LD_IND && ptr_inc) begin
            ptr_next = ptr_reg + PW'(1);
          end
          state_next = tx_enter;
        end
      end
      dpa_pkg::ST_GUARD: begin
        if (bit_tick_reg) begin
          guard_cnt_next = guard_cnt_reg - 8'h01;
          if (guard_cnt_reg == 8'h00) begin
            state_next = dpa_pkg::ST_TX;
          end
        end
      end
      dpa_pkg::ST_TX: begin
        if (tx_ready_in) begin
          dir_tx_next = 1'b1;
          cnt_next    = cnt_inc;
          if (instr_reg.op == dpa_pkg::OP_CS_LOAD || last) begin
            done = 1'b1;
          end else if (instr_reg.op == dpa_pkg::OP_LD_IND && ptr_self) begin
            tx_data_next = get_byte(ptr_reg, cnt_inc);
          end else begin
            state_next = dpa_pkg::ST_BUSRD;
          end
        end
      end
      dpa_pkg::ST_ERROR: begin
        if (link_break_in) begin
          state_next = dpa_pkg::ST_IDLE;
        end
      end
      default: state_next = dpa_pkg::ST_IDLE;
    endcase
    if (done) begin
      state_next = dpa_pkg::ST_IDLE;
      if (rep_act_reg && rep_cnt_reg != '0) begin
        rep_cnt_next = rep_cnt_reg - PW'(1);
        again_next   = 1'b1;
      end else begin
        rep_act_next = 1'b0;
      end
    end
    if (state_reg != dpa_pkg::ST_ERROR && (link_exc_in || link_break_in)) begin
      state_next   = dpa_pkg::ST_ERROR;
      rep_act_next = 1'b0;
      rep_arm_next = 1'b0;
      again_next   = 1'b0;
      csr_wr       = 1'b0;
      key_ok       = 1'b0;
    end
  end

  // --------------------------------------------------------------------
  // bit-rate enable for guard timing
  // --------------------------------------------------------------------
  always_ff @(posedge ref_clk_in or posedge sys_rst_in) begin
    if (sys_rst_in) begin
      div_cnt_reg  <= 16'h0000;
      bit_tick_reg <= 1'b0;
    end else begin
      div_cnt_reg  <= div_wrap ? 16'h0000 : div_cnt_reg + 16'h0001;
      bit_tick_reg <= div_wrap;
    end
  end

  // --------------------------------------------------------------------
  // registers
  // --------------------------------------------------------------------
  always_ff @(posedge ref_clk_in or posedge sys_rst_in) begin
    if (sys_rst_in) begin
      state_reg     <= dpa_pkg::ST_IDLE;
      instr_reg     <= '0;
      ptr_reg       <= '0;
      acc_reg       <= '0;
      rep_cnt_reg   <= '0;
      cnt_reg       <= 2'h0;
      addr_ph_reg   <= 1'b0;
      rep_arm_reg   <= 1'b0;
      rep_act_reg   <= 1'b0;
      again_reg     <= 1'b0;
      dir_tx_reg    <= 1'b0;
      tx_data_reg   <= 8'h00;
      wdata_reg     <= 8'h00;
      key_sh_reg    <= 64'h0;
      guard_cnt_reg <= 8'h00;
    end else begin
      state_reg     <= state_next;
      instr_reg     <= instr_next;
      ptr_reg       <= ptr_next;
      acc_reg       <= acc_next;
      rep_cnt_reg   <= rep_cnt_next;
      cnt_reg       <= cnt_next;
      addr_ph_reg   <= addr_ph_next;
      rep_arm_reg   <= rep_arm_next;
      rep_act_reg   <= rep_act_next;
      again_reg     <= again_next;
      dir_tx_reg    <= dir_tx_next;
      tx_data_reg   <= tx_data_next;
      wdata_reg     <= wdata_next;
      key_sh_reg    <= key_sh_next;
      guard_cnt_reg <= guard_cnt_next;
    end
  end

  // --------------------------------------------------------------------
  // outputs
  // --------------------------------------------------------------------
  // strobes are plain state decodes; address and data come from flops
  assign bus_req_out.addr  = acc_reg;
  assign bus_req_out.wdata = wdata_reg;
  assign bus_req_out.rd    = (state_reg == dpa_pkg::ST_BUSRD);
  assign bus_req_out.wr    = (state_reg == dpa_pkg::ST_BUSWR);
  assign tx_byte_out       = tx_data_reg;
  assign tx_valid_out      = (state_reg == dpa_pkg::ST_TX);
  assign link_dir_tx_out   = dir_tx_reg;

endmodule

// >>> sim/dpa_prog.sv
module dpa_prog (
  // clock
  input  wire logic          ref_clk_in,
  // link from the device
  input  wire logic          tx_valid_out,
  input  wire logic    [7:0] tx_byte_out,
  // link to the device
  output dpa_pkg::dpa_byte_t rx_in,
  output logic               tx_ready_in
);
  timeunit 1ns;
  timeprecision 1ps;
  // ----------------------------------------
  // byte level programmer
  // ----------------------------------------
  initial begin
    rx_in = '0;
    tx_ready_in = 1'b0;
  end
  // idle data inverted so a stale byte is never reused
  task automatic send(input logic [7:0] b);
    @(posedge ref_clk_in) #1;
    rx_in = {b, 1'b1};
    @(posedge ref_clk_in) #1;
    rx_in = {~b, 1'b0};
  endtask
  task automatic get(output logic [7:0] b, output int n, input int lat);
    n = 0;
    do begin
      @(posedge ref_clk_in) #1;
      n++;
    end while (tx_valid_out !== 1'b1 && n < 2000);
    repeat (lat) @(posedge ref_clk_in) #1;
    b = tx_byte_out;
    tx_ready_in = 1'b1;
    @(posedge ref_clk_in) #1;
    tx_ready_in = 1'b0;
  endtask
endmodule

// >>> sim/dpa_ctrl_core_assertions.sv
module dpa_ctrl_core_chk #(
  parameter int BIT_DIV = 16
) (
  // clock and reset
  input wire logic                  ref_clk_in,
  input wire logic                  sys_rst_in,
  // link
  input wire dpa_pkg::dpa_byte_t    rx_in,
  input wire logic                  link_exc_in,
  input wire logic                  tx_ready_in,
  input wire logic            [7:0] tx_byte_out,
  input wire logic                  tx_valid_out,
  input wire logic                  link_dir_tx_out,
  // bus and control
  input wire dpa_pkg::dpa_bus_req_t bus_req_out,
  input wire logic                  bus_ack_in,
  input wire logic                  device_reset_out
);
  timeunit 1ns;
  timeprecision 1ps;
  default clocking cb @(posedge ref_clk_in);
  endclocking
  default disable iff (sys_rst_in);
  // ----------------------------------------
  // link and bus properties
  // ----------------------------------------
  property p_wr_hold;
    bus_req_out.wr && !bus_ack_in |=> bus_req_out.wr && $stable(bus_req_out);
  endproperty
  a_wr_hold: assert property (p_wr_hold)
    else $error("store request changed before ack");
  property p_rd_hold;
    bus_req_out.rd && !bus_ack_in |=> bus_req_out.rd && $stable(bus_req_out);
  endproperty
  a_rd_hold: assert property (p_rd_hold)
    else $error("load request changed before ack");
  property p_ack_drop;
    (bus_req_out.rd || bus_req_out.wr) && bus_ack_in |=> !bus_req_out.wr;
  endproperty
  a_ack_drop: assert property (p_ack_drop)
    else $error("store kept after ack");
  property p_tx_hold;
    tx_valid_out && !tx_ready_in |=> tx_valid_out && $stable(tx_byte_out);
  endproperty
  a_tx_hold: assert property (p_tx_hold)
    else $error("tx byte changed before ready");
  property p_dir_tx;
    tx_valid_out && tx_ready_in |=> link_dir_tx_out;
  endproperty
  a_dir_tx: assert property (p_dir_tx)
    else $error("direction not tx after send");
  // two idle bits at divider 2 are four cycles
  property p_guard;
    rx_in.valid |=> !tx_valid_out [*4];
  endproperty
  a_guard: assert property (p_guard)
    else $error("tx without guard time");
  property p_exc;
    link_exc_in |=> !tx_valid_out && !bus_req_out.wr;
  endproperty
  a_exc: assert property (p_exc)
    else $error("activity after link exception");
  property p_rst_chg;
    $changed(device_reset_out) |-> $past(rx_in.valid, 1) ||
      $past(rx_in.valid, 2) || $past(rx_in.valid, 3);
  endproperty
  a_rst_chg: assert property (p_rst_chg)
    else $error("reset output changed without a store");
endmodule
bind dpa_ctrl_core dpa_ctrl_core_chk #(.BIT_DIV(BIT_DIV)) i_chk (
  .ref_clk_in(ref_clk_in), .sys_rst_in(sys_rst_in), .rx_in(rx_in),
  .link_exc_in(link_exc_in), .tx_ready_in(tx_ready_in),
  .tx_byte_out(tx_byte_out), .tx_valid_out(tx_valid_out),
  .link_dir_tx_out(link_dir_tx_out), .bus_req_out(bus_req_out),
  .bus_ack_in(bus_ack_in), .device_reset_out(device_reset_out));

// >>> sim/test_debug_port_addr_csr_regs.sv
module test_debug_port_addr_csr_regs;
  timeunit 1ns;
  timeprecision 1ps;
  localparam int BD = 2;
  logic                  ref_clk_in, sys_rst_in, link_exc_in, link_break_in;
  logic                  tx_ready_in, tx_valid_out, link_dir_tx_out;
  logic                  bus_ack_in, nvm_en_out, device_reset_out;
  logic            [7:0] tx_byte_out, bus_rdata_in, rv;
  logic           [31:0] lfsr, p, a;
  dpa_pkg::dpa_byte_t    rx_in;
  dpa_pkg::dpa_bus_req_t bus_req_out;
  int                    n_mismatch = 0;
  int                    n_tests = 0;
  int                    cyc = 0;
  int                    wt, g;
  logic           [39:0] q_wr[$];
  // ----------------------------
  // harness
  // ----------------------------
  dpa_ctrl_core #(.BIT_DIV(BD)) i_dpa_ctrl_core (
    .ref_clk_in(ref_clk_in), .sys_rst_in(sys_rst_in), .rx_in(rx_in),
    .link_exc_in(link_exc_in), .link_break_in(link_break_in),
    .tx_ready_in(tx_ready_in), .tx_byte_out(tx_byte_out),
    .tx_valid_out(tx_valid_out), .link_dir_tx_out(link_dir_tx_out),
    .bus_req_out(bus_req_out), .bus_rdata_in(bus_rdata_in),
    .bus_ack_in(bus_ack_in), .nvm_en_out(nvm_en_out),
    .device_reset_out(device_reset_out));
  dpa_prog i_dpa_prog (
    .ref_clk_in(ref_clk_in), .tx_valid_out(tx_valid_out),
    .tx_byte_out(tx_byte_out), .rx_in(rx_in), .tx_ready_in(tx_ready_in));
  function automatic logic [31:0] rnd();
    lfsr = {lfsr[30:0], lfsr[31] ^ lfsr[21] ^ lfsr[1] ^ lfsr[0]};
    return lfsr;
  endfunction
  task automatic chk(input logic [39:0] seen, input logic [39:0] exp);
    n_tests++;
    if (seen !== exp) begin
      n_mismatch++;
      $display("MISMATCH t=%0t seen %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic tk(input int n);
    repeat (n) @(posedge ref_clk_in);
    #1;
  endtask
  task automatic snd(input logic [7:0] b);
    i_dpa_prog.send(b);
  endtask
  task automatic rx1();
    i_dpa_prog.get(rv, wt, int'(rnd() % 4));
  endtask
  task automatic rd(input logic [1:0] o);
    snd({6'h20, o});
    rx1();
  endtask
  task automatic wr(input logic [1:0] o, input logic [7:0] v);
    snd({6'h30, o});
    snd(v);
    tk(3);
  endtask
  task automatic rdp(input logic [31:0] e);
    snd(8'h2B);
    for (int i = 0; i < 4; i++) begin
      rx1();
      chk(rv, e[i*8 +: 8]);
    end
  endtask
  task automatic end_of_test();
    $display("tests %0d mismatches %0d", n_tests, n_mismatch);
    if (n_mismatch == 0 && n_tests > 0)
      $display("verification passed");
    else
      $display("verification failed");
    $finish;
  endtask
  initial begin
    ref_clk_in = 1'b0;
    forever #2.5 ref_clk_in = ~ref_clk_in;
  end
  always @(posedge ref_clk_in) begin
    cyc++;
    if (cyc == 20000) begin
      n_mismatch++;
      end_of_test();
    end
  end
  // random-latency slave; stores checked against the model queue
  initial forever begin
    @(posedge ref_clk_in) #1;
    if ((bus_req_out.rd | bus_req_out.wr) === 1'b1) begin
      tk(int'(rnd() % 3));
      bus_rdata_in = bus_req_out.addr[7:0] ^ 8'hA5;
      if (bus_req_out.wr === 1'b1)
        chk({bus_req_out.addr, bus_req_out.wdata}, q_wr.pop_front());
      bus_ack_in = 1'b1;
      tk(1);
      bus_ack_in = 1'b0;
    end
  end
  // ----------------------------
  // scenarios
  // ----------------------------
  initial begin
    lfsr = 32'h4FB34DC4;
    {sys_rst_in, link_exc_in, link_break_in, bus_ack_in} = 4'h8;
    bus_rdata_in = 8'h00;
    tk(12);
    sys_rst_in = 1'b0;
    for (int o = 0; o < 4; o++) begin
      rd(o[1:0]);
      chk(rv, 0);
      chk(wt > 128 * BD, 1);
    end
    // ends on code 7, the shortest turnaround
    for (int s = 0; s < 8; s++) begin
      wr(2'h2, s[7:0]);
      g = 128 >> (s > 6 ? 6 : s);
      rd(2'h2);
      chk(rv, s);
      chk(wt > g * BD && wt <= g * BD + BD, 1);
    end
    wr(2'h1, dpa_pkg::RESET_SIG);
    chk(device_reset_out, 1);
    rd(2'h1);
    chk(rv, 1);
    wr(2'h1, 8'h00);
    chk(device_reset_out, 0);
    wr(2'h3, 8'hFF);
    rd(2'h3);
    chk(rv, 0);
    snd(8'hE0);
    for (int i = 0; i < 8; i++) snd(dpa_pkg::KEY_VALUE[i*8 +: 8]);
    tk(3);
    chk(nvm_en_out, 1);
    rd(2'h0);
    chk(rv, 8'h02);
    wr(2'h0, 8'h00);
    chk(nvm_en_out, 0);
    p = rnd();
    snd(8'h6B);
    for (int i = 0; i < 4; i++) snd(p[i*8 +: 8]);
    snd(8'h68);
    snd(8'h3C);
    p[7:0] = 8'h3C;
    rdp(p);
    snd(8'h21);
    for (int i = 0; i < 2; i++) begin
      a = p + i;
      rx1();
      chk(rv, a[7:0] ^ 8'hA5);
    end
    snd(8'hA0);
    snd(8'h02);
    snd(8'h64);
    for (int i = 0; i < 3; i++) begin
      a = p + i;
      q_wr.push_back({a, a[15:8]});
      snd(a[15:8]);
      while (q_wr.size() > 0 || bus_ack_in) tk(1);
    end
    wr(2'h2, 8'h07);
    rdp(p + 3);
    a = rnd();
    snd(8'h4D);
    for (int i = 0; i < 4; i++) snd(a[i*8 +: 8]);
    for (int i = 0; i < 2; i++) begin
      q_wr.push_back({a + i, a[23:16]});
      snd(a[23:16]);
      while (q_wr.size() > 0 || bus_ack_in) tk(1);
    end
    rdp(a);
    snd(8'h00);
    snd(8'h5A);
    rx1();
    chk(rv, 8'h5A ^ 8'hA5);
    link_exc_in = 1'b1;
    tk(1);
    link_exc_in = 1'b0;
    snd(8'h80);
    tk(300);
    chk(tx_valid_out, 0);
    link_break_in = 1'b1;
    tk(1);
    link_break_in = 1'b0;
    rd(2'h0);
    chk(rv, 0);
    end_of_test();
  end
endmodule
